// [logic/cancr_pkg.sv]
// constants and types shared by the command and reset control ends
package cancr_pkg;
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 8;
  // register offsets
  localparam logic [4:0]  OFS_CTRL      = 5'h00;
  localparam logic [4:0]  OFS_CMD       = 5'h01;
  localparam logic [4:0]  OFS_STAT      = 5'h02;
  localparam logic [4:0]  OFS_PROT_LO   = 5'h04;
  localparam logic [4:0]  OFS_PROT_HI   = 5'h08;
  localparam int          PROT_N        = 5;
  // control register fields
  localparam int          CT_RESET_REQ  = 0;
  localparam int          CT_REF_OUT    = 5;
  localparam int          CT_EDGE_SYNC  = 6;
  localparam logic [7:0]  CT_FREE_MASK  = 8'h9e;
  localparam logic [7:0]  CTRL_RESET    = 8'h21;
  // command register fields
  localparam int          CM_SEND       = 0;
  localparam int          CM_ABORT      = 1;
  localparam int          CM_RELEASE    = 2;
  localparam int          CM_CLR_OVR    = 3;
  localparam int          CM_SLEEP      = 4;
  localparam int          CM_WAKE_SEL   = 5;
  localparam int          CM_SW_B       = 6;
  localparam int          CM_SW_A       = 7;
  localparam logic [3:0]  CM_ACTION_RD  = 4'hf;
  // status register fields
  localparam int          ST_RX_FULL    = 0;
  localparam int          ST_OVERRUN    = 1;
  localparam int          ST_TX_FREE    = 2;
  localparam int          ST_TX_DONE    = 3;
  localparam int          ST_TX_BUSY    = 5;
  localparam int          ST_BUS_OFF    = 7;
  // timing and buffer counts
  localparam logic [3:0]  BUS_FREE_BITS = 4'hb;
  localparam logic [7:0]  FREES_NORMAL  = 8'h01;
  localparam logic [7:0]  FREES_BUS_OFF = 8'h80;
  localparam logic [1:0]  RELEASE_GAP   = 2'h3;
  localparam logic [1:0]  RX_BUFS       = 2'h2;

  typedef enum logic [3:0] {
    MD_RESET = 4'h1,
    MD_WAIT  = 4'h2,
    MD_RUN   = 4'h4,
    MD_SLEEP = 4'h8
  } cancr_mode_t;
endpackage

// [logic/cancr_if.sv]
// register port between the cpu end and the controller end
`timescale 1ns/1ns
`default_nettype none
interface cancr_if;
  logic [cancr_pkg::ADDR_W-1:0] addr;
  logic [cancr_pkg::DATA_W-1:0] wdata;
  logic                         wr;
  logic                         rd;
  logic [cancr_pkg::DATA_W-1:0] rdata;
  modport device (input addr, input wdata, input wr, input rd, output rdata);
  modport host   (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// [logic/cancr_device.sv]
// controller end: command register, reset request, bus-free waits and sleep
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - ref and sync bits change only under reset
// - external reset sets ref output, sync undefined
// - external reset or bus-off forces reset request
// - after cpu/external reset wait one bus-free
// - after bus-off wait 128 bus-free conditions
// - registers 4 to 8 only in reset
// - command bits 0..3 read back one
// - wake select picks single-ended or differential wake
// - sleep only without pending irq or activity
// - wake on sleep clear or activity, irq
// - bus wake blocks reception until bus-free
// - sleep bit reads real sleep state
// - clear overrun on one, zero ignored
// - cpu clears overrun with second release
// - release frees the cpu receive buffer
// - cpu spaces releases at least three clocks
// - abort cancels only a not-started send
// - send request only cancelled by abort or reset request
// - cpu checks completion after abort settles
// - switch bits read back current state
// - switch bits route comparators or reference
// - cpu writes wake select with sleep
// - reset request aborts traffic, clear resumes
module cancr_device (
  // clock and reset
  input  wire logic     ref_clk,
  input  wire logic     resetn,
  // cpu side
  cancr_if.device       bus,
  // external reset pin and bus state
  input  wire logic     extReset,
  input  wire logic     busOffEvent,
  input  wire logic     bitTick,
  input  wire logic     bitRecessive,
  input  wire logic     busActivity,
  input  wire logic     irqPending,
  // wake detectors
  input  wire logic     diffWake,
  input  wire logic     singleWakeA,
  input  wire logic     singleWakeB,
  // comparators and reference level
  input  wire logic     compA,
  input  wire logic     compB,
  input  wire logic     refLevel,
  // transfer layer
  input  wire logic     txStarted,
  input  wire logic     txFinished,
  input  wire logic     rxStored,
  // controller outputs
  output logic          inReset,
  output logic          busOn,
  output logic          sleeping,
  output logic          rxEnable,
  output logic          txRequest,
  output logic          wakeIrq,
  output logic          refOutEnable,
  output logic          edgeSync,
  output logic          busInA,
  output logic          busInB
);
  import cancr_pkg::*;
  typedef struct packed {
    cancr_mode_t         mode;
    logic [7:0]          ctrl;
    logic                swA;
    logic                swB;
    logic                wakeSel;
    logic                sleepReq;
    logic                txPend;
    logic                txBusy;
    logic                txDone;
    logic                overrun;
    logic [1:0]          rxCount;
    logic                busOff;
    logic                offCause;
    logic                rxBlock;
    logic [7:0]          freesLeft;
    logic [3:0]          recBits;
    logic                wakeIrq;
    logic                inA;
    logic                inB;
    logic [PROT_N-1:0][7:0] prot;
    logic [7:0]          rdata;
  } cancr_dev_state_t;

  cancr_dev_state_t s;
  cancr_dev_state_t n;

  function automatic logic isProt(input logic [ADDR_W-1:0] a);
    isProt = (a >= OFS_PROT_LO) && (a <= OFS_PROT_HI);
  endfunction

  logic busFree;
  logic wakeEvent;
  logic wrCtrl;
  logic wrCmd;
  logic [7:0] status;
  logic [2:0] protIdx;

  always_comb begin
    busFree   = bitTick && bitRecessive && (s.recBits == BUS_FREE_BITS - 4'h1);
    wakeEvent = s.wakeSel ? (singleWakeA || singleWakeB) : diffWake;
    wrCtrl    = bus.wr && (bus.addr == OFS_CTRL);
    wrCmd     = bus.wr && (bus.addr == OFS_CMD);
    protIdx   = 3'(bus.addr - OFS_PROT_LO);
    status    = 8'h00;
    status[ST_BUS_OFF] = s.busOff;
    status[ST_TX_BUSY] = s.txBusy;
    status[ST_TX_DONE] = s.txDone;
    status[ST_TX_FREE] = !s.txPend;
    status[ST_OVERRUN] = s.overrun;
    status[ST_RX_FULL] = (s.rxCount != 2'h0);
  end

  always_comb begin
    n = s;
    n.wakeIrq = 1'b0;
    // eleven recessive bit times in a row make one bus-free condition
    if (bitTick) begin
      n.recBits = (!bitRecessive || busFree) ? 4'h0 : s.recBits + 4'h1;
    end
    if (busFree) begin
      n.rxBlock = 1'b0;
    end
    // control register
    if (wrCtrl) begin
      n.ctrl = (s.ctrl & ~CT_FREE_MASK) | (bus.wdata & CT_FREE_MASK);
      n.ctrl[CT_RESET_REQ] = bus.wdata[CT_RESET_REQ];
      if (s.ctrl[CT_RESET_REQ]) begin
        n.ctrl[CT_REF_OUT]   = bus.wdata[CT_REF_OUT];
        n.ctrl[CT_EDGE_SYNC] = bus.wdata[CT_EDGE_SYNC];
      end
      if (s.ctrl[CT_RESET_REQ] && !bus.wdata[CT_RESET_REQ]) begin
        // leaving reset: a bus-off reset asks for the long wait
        n.freesLeft = s.offCause ? FREES_BUS_OFF : FREES_NORMAL;
        n.mode      = MD_WAIT;
      end
    end
    // command register; action bits fire only on a written one
    if (wrCmd) begin
      n.swA     = bus.wdata[CM_SW_A];
      n.swB     = bus.wdata[CM_SW_B];
      n.wakeSel = bus.wdata[CM_WAKE_SEL];
      n.sleepReq = bus.wdata[CM_SLEEP];
      if (bus.wdata[CM_SEND] && !s.ctrl[CT_RESET_REQ] && !s.txPend) begin
        n.txPend = 1'b1;
        n.txDone = 1'b0;
      end
      if (bus.wdata[CM_ABORT] && s.txPend && !s.txBusy) begin
        n.txPend = 1'b0;
      end
      if (bus.wdata[CM_RELEASE] && s.rxCount != 2'h0) begin
        n.rxCount = s.rxCount - 2'h1;
      end
      if (bus.wdata[CM_CLR_OVR]) begin
        n.overrun = 1'b0;
      end
    end
    // protocol registers at 4..8 accept writes only under reset
    if (bus.wr && isProt(bus.addr) && s.ctrl[CT_RESET_REQ]) begin
      n.prot[protIdx] = bus.wdata;
    end
    // routing, both switches low holds the last route
    case ({s.swA, s.swB})
      2'b11: begin
        n.inA = compA;
        n.inB = compB;
      end
      2'b10: begin
        n.inA = compA;
        n.inB = refLevel;
      end
      2'b01: begin
        n.inA = refLevel;
        n.inB = compB;
      end
      default: begin
      end
    endcase
    // transfer layer events
    if (txStarted && s.txPend && s.mode == MD_RUN) begin
      n.txBusy = 1'b1;
    end
    if (txFinished && s.txBusy) begin
      n.txBusy = 1'b0;
      n.txPend = 1'b0;
      n.txDone = 1'b1;
    end
    if (rxStored && s.mode == MD_RUN && !s.rxBlock) begin
      // a new overrun beats a clear in the same cycle
      if (n.rxCount == RX_BUFS) begin
        n.overrun = 1'b1;
      end else begin
        n.rxCount = n.rxCount + 2'h1;
      end
    end
    // operating mode
    case (s.mode)
      MD_RESET: begin
      end
      MD_WAIT: begin
        if (busFree) begin
          n.freesLeft = s.freesLeft - 8'h01;
          if (s.freesLeft == 8'h01) begin
            n.mode     = MD_RUN;
            n.busOff   = 1'b0;
            n.offCause = 1'b0;
          end
        end
      end
      MD_RUN: begin
        if (n.sleepReq && !irqPending && !busActivity && !s.txBusy) begin
          n.mode = MD_SLEEP;
        end
      end
      MD_SLEEP: begin
        if (!n.sleepReq || wakeEvent) begin
          n.mode    = MD_RUN;
          n.wakeIrq = 1'b1;
          if (wakeEvent) begin
            // the waking frame is lost; listen again after bus-free
            n.rxBlock  = 1'b1;
            n.sleepReq = 1'b0;
          end
        end
      end
      default: n.mode = MD_RESET;
    endcase
    // forced reset and reset request win over everything above
    if (busOffEvent) begin
      n.busOff   = 1'b1;
      n.offCause = 1'b1;
    end
    if (extReset || busOffEvent) begin
      n.ctrl[CT_RESET_REQ] = 1'b1;
    end
    if (extReset) begin
      n.ctrl[CT_REF_OUT] = 1'b1;
      n.offCause         = 1'b0;
    end
    if (n.ctrl[CT_RESET_REQ]) begin
      n.mode   = MD_RESET;
      n.txPend = 1'b0;
      n.txBusy = 1'b0;
    end
    // read data one cycle after the strobe
    n.rdata = 8'h00;
    if (bus.rd) begin
      if (bus.addr == OFS_CTRL) begin
        n.rdata = s.ctrl;
      end else if (bus.addr == OFS_CMD) begin
        n.rdata = {s.swA, s.swB, s.wakeSel, (s.mode == MD_SLEEP), CM_ACTION_RD};
      end else if (bus.addr == OFS_STAT) begin
        n.rdata = status;
      end else if (isProt(bus.addr) && s.ctrl[CT_RESET_REQ]) begin
        n.rdata = s.prot[protIdx];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s      <= '0;
      s.mode <= MD_RESET;
      s.ctrl <= CTRL_RESET;
    end else begin
      s <= n;
    end
  end

  assign bus.rdata    = s.rdata;
  assign inReset      = s.ctrl[CT_RESET_REQ];
  assign busOn        = !s.busOff;
  assign sleeping     = (s.mode == MD_SLEEP);
  assign rxEnable     = (s.mode == MD_RUN) && !s.rxBlock;
  assign txRequest    = s.txPend && !s.txBusy && (s.mode == MD_RUN);
  assign wakeIrq      = s.wakeIrq;
  assign refOutEnable = s.ctrl[CT_REF_OUT];
  assign edgeSync     = s.ctrl[CT_EDGE_SYNC];
  assign busInA       = s.inA;
  assign busInB       = s.inB;
endmodule
`default_nettype wire

// [logic/cancr_host.sv]
// cpu end: forwards register accesses and paces release commands
`timescale 1ns/1ns
`default_nettype none
module cancr_host (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  // software port
  input  wire logic [cancr_pkg::ADDR_W-1:0] addr,
  input  wire logic [cancr_pkg::DATA_W-1:0] wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [cancr_pkg::DATA_W-1:0] rdata,
  output logic                              busy,
  output logic                              checkDone,
  // controller side
  cancr_if.host                             bus
);
  import cancr_pkg::*;
  typedef struct packed {
    logic                pend;
    logic [ADDR_W-1:0]   pAddr;
    logic [DATA_W-1:0]   pData;
    logic [1:0]          gap;
    logic                checkDue;
  } cancr_host_state_t;

  cancr_host_state_t s;
  cancr_host_state_t n;

  logic [DATA_W-1:0] cmdData;
  logic              isRelease;
  logic              gapOk;
  logic              issue;

  always_comb begin
    // overrun clear rides only on a release command
    cmdData = wdata;
    if (addr == OFS_CMD && wdata[CM_CLR_OVR]) begin
      cmdData[CM_RELEASE] = 1'b1;
    end
    isRelease = wr && addr == OFS_CMD && cmdData[CM_RELEASE];
    gapOk     = (s.gap >= RELEASE_GAP - 2'h1);
    issue     = s.pend && gapOk;
  end

  always_comb begin
    n = s;
    if (s.gap != RELEASE_GAP) begin
      n.gap = s.gap + 2'h1;
    end
    // a too-early release waits; a stall costs cycles, not a lost command
    if (issue) begin
      n.pend = 1'b0;
      n.gap  = 2'h0;
    end else if (isRelease && !s.pend) begin
      if (gapOk) begin
        n.gap = 2'h0;
      end else begin
        n.pend  = 1'b1;
        n.pAddr = addr;
        n.pData = cmdData;
      end
    end
    // after an abort, completion is worth reading once the buffer frees
    if (wr && addr == OFS_CMD && wdata[CM_ABORT]) begin
      n.checkDue = 1'b1;
    end else if (rd && addr == OFS_STAT) begin
      n.checkDue = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s     <= '0;
      s.gap <= RELEASE_GAP;
    end else begin
      s <= n;
    end
  end

  always_comb begin
    bus.addr  = addr;
    bus.wdata = cmdData;
    bus.wr    = wr && !s.pend && !(isRelease && !gapOk);
    bus.rd    = rd && !issue;
    if (issue) begin
      bus.addr  = s.pAddr;
      bus.wdata = s.pData;
      bus.wr    = 1'b1;
    end
  end

  assign rdata     = bus.rdata;
  assign busy      = s.pend;
  assign checkDone = s.checkDue;
endmodule
`default_nettype wire

// [verification/cancr_checker.sv]
// assertions on the register port between the cpu end and the controller end
`timescale 1ns/1ns
`default_nettype none
module cancr_checker (
  // clock and reset
  input wire logic                         ref_clk,
  input wire logic                         resetn,
  // register port
  input wire logic [cancr_pkg::ADDR_W-1:0] addr,
  input wire logic [cancr_pkg::DATA_W-1:0] wdata,
  input wire logic                         wr,
  input wire logic                         rd,
  input wire logic [cancr_pkg::DATA_W-1:0] rdata
);
  import cancr_pkg::*;
  // plain storage bits are zero after reset, so the shadow needs no valid flag
  typedef struct packed {
    logic [7:0] ctl;
    logic [2:0] cmd;
  } cancr_shadow_t;
  cancr_shadow_t shadow;
  cancr_shadow_t next_shadow;
  logic          relW;
  assign relW = wr && addr == OFS_CMD && wdata[CM_RELEASE];
  always_comb begin
    next_shadow = shadow;
    if (wr && addr == OFS_CTRL) next_shadow.ctl = wdata;
    if (wr && addr == OFS_CMD) next_shadow.cmd = wdata[7:5];
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) shadow <= '0;
    else shadow <= next_shadow;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_no_wr_rd: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_cmd_low_ones: assert property (rd && addr == OFS_CMD |=> rdata[3:0] == CM_ACTION_RD)
    else $error("command action bits did not read as ones");
  a_release_gap: assert property (relW |=> (!relW) [*2])
    else $error("release commands closer than three cycles");
  a_overrun_release: assert property (wr && addr == OFS_CMD && wdata[CM_CLR_OVR] |-> wdata[CM_RELEASE])
    else $error("overrun clear without release");
  a_rdata_idle: assert property (rdata != 8'h00 |-> $past(rd))
    else $error("read data outside the answer cycle");
  a_unmapped_zero: assert property (rd && (addr == 5'h03 || addr > OFS_PROT_HI) |=> rdata == 8'h00)
    else $error("unmapped address returned data");
  a_ctrl_storage: assert property (rd && addr == OFS_CTRL |=> (rdata & CT_FREE_MASK) == (shadow.ctl & CT_FREE_MASK))
    else $error("control storage bits lost");
  a_switch_readback: assert property (rd && addr == OFS_CMD |=> rdata[7:5] == shadow.cmd)
    else $error("switch or wake select bits wrong");
  c_release: cover property (relW);
  c_cmd_read: cover property (rd && addr == OFS_CMD);
  c_ctrl_write: cover property (wr && addr == OFS_CTRL);
endmodule
`default_nettype wire

// [verification/tb_can_command_and_reset_control.sv]
// self-checking bench joining the cpu end and the controller end
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin badCount++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_can_command_and_reset_control;
  import cancr_pkg::*;
  localparam int LIMIT = 8000;
  logic        ref_clk, resetn, swWr, swRd, busy, checkDone;
  logic [4:0]  swAddr;
  logic [7:0]  swWdata, swRdata, d;
  logic        extReset, busOffEvent, bitTick, bitRecessive, busActivity, irqPending;
  logic        diffWake, singleWakeA, compA, compB, refLevel, txStarted, txFinished, rxStored;
  logic        inReset, busOn, sleeping, rxEnable, txRequest, wakeIrq, refOutEnable, edgeSync;
  logic        busInA, busInB, expA, expB, singleWakeB;
  logic [15:0] rnd;
  int          badCount, checks, cycles, wakes, rxCount, ovr, w;
  cancr_if cancr_if_i ();
  cancr_host cancr_host_i (.ref_clk(ref_clk), .resetn(resetn), .addr(swAddr), .wdata(swWdata),
    .wr(swWr), .rd(swRd), .rdata(swRdata), .busy(busy), .checkDone(checkDone), .bus(cancr_if_i));
  cancr_device cancr_device_i (.ref_clk(ref_clk), .resetn(resetn), .bus(cancr_if_i),
    .extReset(extReset), .busOffEvent(busOffEvent), .bitTick(bitTick),
    .bitRecessive(bitRecessive), .busActivity(busActivity), .irqPending(irqPending),
    .diffWake(diffWake), .singleWakeA(singleWakeA), .singleWakeB(singleWakeB), .compA(compA),
    .compB(compB), .refLevel(refLevel), .txStarted(txStarted), .txFinished(txFinished),
    .rxStored(rxStored), .inReset(inReset), .busOn(busOn), .sleeping(sleeping),
    .rxEnable(rxEnable), .txRequest(txRequest), .wakeIrq(wakeIrq),
    .refOutEnable(refOutEnable), .edgeSync(edgeSync), .busInA(busInA), .busInB(busInB));
  cancr_checker cancr_checker_i (.ref_clk(ref_clk), .resetn(resetn), .addr(cancr_if_i.addr),
    .wdata(cancr_if_i.wdata), .wr(cancr_if_i.wr), .rd(cancr_if_i.rd), .rdata(cancr_if_i.rdata));
  always #20 ref_clk = ~ref_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic summarize();
    if (badCount == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // wake pulses are one cycle, so they are counted here rather than polled
  always @(posedge ref_clk) begin
    cycles++;
    if (wakeIrq === 1'b1) wakes++;
    if (cycles == LIMIT) begin
      badCount++;
      summarize();
    end
  end
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic wrReg(input logic [4:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    swAddr <= a;
    swWdata <= v;
    swWr <= 1'b1;
    @(posedge ref_clk);
    swWr <= 1'b0;
  endtask
  task automatic rdReg(input logic [4:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge ref_clk);
    swRd <= 1'b0;
    #1 v = swRdata;
  endtask
  task automatic chkReg(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] v;
    rdReg(a, v);
    `CHK(v, e)
  endtask
  task automatic ticks(input int n, input logic rec);
    repeat (n) begin
      @(posedge ref_clk);
      bitTick <= 1'b1;
      bitRecessive <= rec;
      @(posedge ref_clk);
      bitTick <= 1'b0;
      bitRecessive <= 1'b1;
    end
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      0: rxStored <= 1'b1;
      1: txStarted <= 1'b1;
      2: txFinished <= 1'b1;
      3: busOffEvent <= 1'b1;
      4: diffWake <= 1'b1;
      5: singleWakeA <= 1'b1;
      default: singleWakeB <= 1'b1;
    endcase
    @(posedge ref_clk);
    {rxStored, txStarted, txFinished, busOffEvent, diffWake, singleWakeA, singleWakeB} <= '0;
  endtask
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    {swAddr, swWdata, swWr, swRd, expA, expB} = '0;
    {extReset, busOffEvent, bitTick, busActivity, irqPending, diffWake, singleWakeA} = '0;
    {compA, compB, refLevel, txStarted, txFinished, rxStored, singleWakeB} = '0;
    bitRecessive = 1'b1;
    {badCount, checks, cycles, wakes, rxCount, ovr} = '0;
    rnd = 16'hf296;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    settle();
    `CHK({inReset, refOutEnable, busOn}, 3'h7)
    chkReg(OFS_CTRL, CTRL_RESET);
    chkReg(OFS_CMD, 8'h0f);
    wrReg(OFS_PROT_LO, 8'h5a);
    wrReg(OFS_PROT_HI, 8'ha5);
    chkReg(OFS_PROT_LO, 8'h5a);
    chkReg(OFS_PROT_HI, 8'ha5);
    wrReg(OFS_CTRL, 8'h40);
    settle();
    `CHK({inReset, refOutEnable, edgeSync}, 3'h1)
    wrReg(OFS_CTRL, 8'h20);
    chkReg(OFS_CTRL, 8'h40);
    chkReg(OFS_PROT_LO, 8'h00);
    chkReg(5'h1f, 8'h00);
    // a dominant bit restarts the bus-free count
    ticks(5, 1'b1);
    ticks(1, 1'b0);
    ticks(10, 1'b1);
    settle();
    `CHK(rxEnable, 1'b0)
    ticks(1, 1'b1);
    settle();
    `CHK({rxEnable, busOn}, 2'h3)
    for (int c = 3; c >= 0; c--) begin
      wrReg(OFS_CMD, {c[1:0], 6'h00});
      rnd = lfsr(rnd);
      @(posedge ref_clk);
      {compA, compB, refLevel} <= rnd[2:0];
      settle();
      if (c != 0) begin
        expA = c[1] ? rnd[2] : rnd[0];
        expB = c[0] ? rnd[1] : rnd[0];
      end
      `CHK({busInA, busInB}, {expA, expB})
      chkReg(OFS_CMD, {c[1:0], 6'h0f});
    end
    wrReg(OFS_CMD, 8'h01);
    settle();
    `CHK(txRequest, 1'b1)
    wrReg(OFS_CMD, 8'h00);
    settle();
    `CHK(txRequest, 1'b1)
    wrReg(OFS_CMD, 8'h02);
    settle();
    `CHK({txRequest, checkDone}, 2'h1)
    wrReg(OFS_CMD, 8'h01);
    pulse(1);
    wrReg(OFS_CMD, 8'h02);
    rdReg(OFS_STAT, d);
    `CHK({d[ST_TX_BUSY], d[ST_TX_DONE], txRequest}, 3'h4)
    pulse(2);
    rdReg(OFS_STAT, d);
    `CHK({d[ST_TX_BUSY], d[ST_TX_DONE], checkDone}, 3'h2)
    repeat (3) begin
      pulse(0);
      if (rxCount < 2) rxCount++;
      else ovr = 1;
    end
    wrReg(OFS_CMD, 8'h00);
    rdReg(OFS_STAT, d);
    `CHK(d[1:0], {ovr[0], rxCount != 0})
    wrReg(OFS_CMD, 8'h04);
    wrReg(OFS_CMD, 8'h0c);
    #1 `CHK(busy, 1'b1)
    for (w = 0; w < 20 && busy !== 1'b0; w++) @(posedge ref_clk);
    `CHK(busy, 1'b0)
    rxCount = 0;
    ovr = 0;
    rdReg(OFS_STAT, d);
    `CHK(d[1:0], {ovr[0], rxCount != 0})
    @(posedge ref_clk);
    {busActivity, irqPending} <= 2'h3;
    wrReg(OFS_CMD, 8'h10);
    @(posedge ref_clk);
    busActivity <= 1'b0;
    settle();
    `CHK(sleeping, 1'b0)
    chkReg(OFS_CMD, 8'h0f);
    @(posedge ref_clk);
    irqPending <= 1'b0;
    settle();
    `CHK(sleeping, 1'b1)
    chkReg(OFS_CMD, 8'h1f);
    w = wakes;
    pulse(4);
    settle();
    `CHK({sleeping, rxEnable, wakes - w}, {2'h0, 32'h1})
    chkReg(OFS_CMD, 8'h0f);
    ticks(11, 1'b1);
    settle();
    `CHK(rxEnable, 1'b1)
    wrReg(OFS_CMD, 8'h30);
    settle();
    pulse(4);
    settle();
    `CHK(sleeping, 1'b1)
    pulse(5);
    settle();
    `CHK(sleeping, 1'b0)
    wrReg(OFS_CMD, 8'h30);
    settle();
    pulse(6);
    settle();
    `CHK(sleeping, 1'b0)
    wrReg(OFS_CMD, 8'h10);
    settle();
    wrReg(OFS_CMD, 8'h00);
    settle();
    `CHK({sleeping, wakes - w}, {1'b0, 32'h4})
    pulse(3);
    settle();
    `CHK({inReset, busOn}, 2'h2)
    wrReg(OFS_CTRL, 8'h40);
    ticks(1397, 1'b1);
    settle();
    `CHK(busOn, 1'b0)
    ticks(11, 1'b1);
    settle();
    `CHK(busOn, 1'b1)
    @(posedge ref_clk);
    extReset <= 1'b1;
    settle();
    `CHK({inReset, refOutEnable}, 2'h3)
    rdReg(OFS_CTRL, d);
    `CHK(d & 8'hbf, 8'h21)
    summarize();
  end
endmodule
`default_nettype wire
